/* File: rtl/eit_edge_irq.sv */
// Purpose: edge interrupt logic with input snapshot and microsecond timestamp
// Assumes: sense lines already filtered and synchronous to clk_in
// Notes: one record is held until acknowledged; a later edge counts as lost
//
// Notes on behaviour
// - rising-edge enable per channel in byte bits 0..3, upper bits reserved
// - falling-edge enable per channel in byte bits 0..3, upper bits reserved
// - enabled edges raise a process interrupt, and a diagnostic one only when lost behind a held record
// - buffer overflow or lost process interrupt raise a diagnostic interrupt
// - record byte one flags edge channels in bits 0..3, default zero
// - record byte two holds input levels captured at interrupt time
// - record carries ticker low 16 bits, high byte 04h, low 05h
// - 32-bit microsecond ticker starts at zero and wraps
// - enabled diagnostic cause issues incoming interrupt with its record
// - diagnostic going interrupt follows automatically once cause clears
// - channel events between incoming and going diagnostic are discarded
// - canopen delivers interrupt data by emergency, others by diagnostics
// - diagnostic interrupt on only for 40h, off for 00h

`timescale 1ns/1ps

module eit_edge_irq (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // sense lines
   input wire logic [3:0] sense_line_in,
   // parameter bytes
   input wire logic [7:0] rise_edge_irq_enable_in,
   input wire logic [7:0] fall_edge_irq_enable_in,
   input wire logic [7:0] diag_enable_in,
   input wire logic canopen_mode_in,
   // diagnostic causes
   input wire logic buffer_overflow_in,
   // process interrupt handshake
   input wire logic proc_ack_in,
   // record read by subindex
   input wire logic [7:0] record_subindex_in,
   output logic [7:0] record_byte_out,
   // process interrupt record
   output logic proc_irq_out,
   output logic proc_emergency_out,
   output logic [7:0] edge_source_flags_out,
   output logic [7:0] input_level_snapshot_out,
   output logic [15:0] timestamp_low_half_out,
   // diagnostic interrupt
   output logic diag_active_out,
   output logic diag_incoming_out,
   output logic diag_going_out,
   output logic [7:0] diag_err_a_out,
   output logic [7:0] diag_err_d_out,
   output logic [7:0] diag_chan_err_out,
   // ticker
   output logic [31:0] ticker_out
);

   logic [1:0] rst_sync;
   logic rst_n;
   logic [31:0] ticker;
   logic [3:0] rise;
   logic [3:0] fall;
   logic [3:0] hit;
   logic diag_on;
   logic cause;
   logic d_act;
   logic p_pend;
   eit_pkg::eit_state_t st;
   eit_pkg::eit_state_t next_st;

   // reset released through two flops so no flop sees a ragged release
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   eit_us_ticker u_ticker (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .ticker_out(ticker)
   );

   // first cycle after reset only primes prev, so a line high at release is no edge
   assign rise = sense_line_in & ~st.prev & rise_edge_irq_enable_in[3:0] & {4{st.armed}};
   assign fall = ~sense_line_in & st.prev & fall_edge_irq_enable_in[3:0] & {4{st.armed}};
   assign hit = rise | fall;
   assign diag_on = (diag_enable_in == eit_pkg::EIT_DIAG_ON);
   assign cause = buffer_overflow_in | st.lost;
   assign d_act = st.dst[eit_pkg::EIT_D_ACT_BIT];
   assign p_pend = st.pst[eit_pkg::EIT_P_PEND_BIT];

   always_comb begin
      next_st = st;
      next_st.armed = 1'b1;
      next_st.prev = sense_line_in;
      next_st.diag_in = 1'b0;
      next_st.diag_go = 1'b0;
      // lost clears once the held record is taken; a new loss below wins
      if (proc_ack_in && p_pend) begin
         next_st.lost = 1'b0;
      end
      case (st.pst)
         eit_pkg::EIT_P_IDLE: begin
            if ((hit != 4'h0) && !d_act) begin
               next_st.flags = hit;
               next_st.snap = sense_line_in;
               next_st.stamp = ticker[15:0];
               next_st.emcy = canopen_mode_in;
               next_st.pst = eit_pkg::EIT_P_PEND;
            end
         end
         eit_pkg::EIT_P_PEND: begin
            if ((hit != 4'h0) && !d_act) begin
               next_st.lost = 1'b1;
               next_st.chan_lost = st.chan_lost | hit;
            end
            if (proc_ack_in) begin
               next_st.pst = eit_pkg::EIT_P_IDLE;
            end
         end
         default: begin
            next_st.pst = eit_pkg::EIT_P_IDLE;
         end
      endcase
      case (st.dst)
         eit_pkg::EIT_D_IDLE: begin
            if (diag_on && cause) begin
               next_st.diag_in = 1'b1;
               next_st.err_d = eit_pkg::EIT_BYTE_RST;
               next_st.err_d[eit_pkg::EIT_ERRD_OVF_BIT] = buffer_overflow_in;
               next_st.err_d[eit_pkg::EIT_ERRD_LOST_BIT] = st.lost;
               next_st.chan_err = {4'h0, st.chan_lost};
               next_st.err_a = eit_pkg::EIT_BYTE_RST;
               next_st.err_a[eit_pkg::EIT_ERRA_CHAN_BIT] = (st.chan_lost != 4'h0);
               next_st.dst = eit_pkg::EIT_D_ACT;
            end
         end
         eit_pkg::EIT_D_ACT: begin
            if (!cause) begin
               next_st.diag_go = 1'b1;
               next_st.chan_lost = 4'h0;
               next_st.dst = eit_pkg::EIT_D_IDLE;
            end
         end
         default: begin
            next_st.dst = eit_pkg::EIT_D_IDLE;
         end
      endcase
      // record bytes as the master addresses them, one cycle behind the subindex
      case (record_subindex_in)
         eit_pkg::EIT_SX_FLAGS: next_st.rd_byte = {4'h0, st.flags};
         eit_pkg::EIT_SX_SNAP: next_st.rd_byte = {4'h0, st.snap};
         eit_pkg::EIT_SX_STAMP_HI: next_st.rd_byte = st.stamp[15:8];
         eit_pkg::EIT_SX_STAMP_LO: next_st.rd_byte = st.stamp[7:0];
         default: next_st.rd_byte = eit_pkg::EIT_BYTE_RST;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.pst <= eit_pkg::EIT_P_IDLE;
         st.dst <= eit_pkg::EIT_D_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign record_byte_out = st.rd_byte;
   assign proc_irq_out = st.pst[eit_pkg::EIT_P_PEND_BIT];
   assign proc_emergency_out = st.emcy;
   assign edge_source_flags_out = {4'h0, st.flags};
   assign input_level_snapshot_out = {4'h0, st.snap};
   assign timestamp_low_half_out = st.stamp;
   assign diag_active_out = st.dst[eit_pkg::EIT_D_ACT_BIT];
   assign diag_incoming_out = st.diag_in;
   assign diag_going_out = st.diag_go;
   assign diag_err_a_out = st.err_a;
   assign diag_err_d_out = st.err_d;
   assign diag_chan_err_out = st.chan_err;
   assign ticker_out = ticker;

   proc_raise_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      (!p_pend && (hit != 4'h0) && !d_act) |=>
      (proc_irq_out && edge_source_flags_out == {4'h0, $past(hit)}))
      else $error("enabled edge did not raise the process interrupt");

   snap_level_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      (!p_pend && (hit != 4'h0) && !d_act) |=>
      (input_level_snapshot_out[3:0] == $past(sense_line_in)))
      else $error("input snapshot differs from levels at the edge");

   stamp_value_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      (!p_pend && (hit != 4'h0) && !d_act) |=>
      (timestamp_low_half_out == $past(ticker[15:0])))
      else $error("timestamp is not the ticker low half");

   flag_resv_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      (edge_source_flags_out[7:4] == 4'h0) && (input_level_snapshot_out[7:4] == 4'h0))
      else $error("reserved record bits not zero");

   edge_gated_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      (!p_pend && (hit == 4'h0)) |=> !proc_irq_out)
      else $error("interrupt raised without an enabled edge");

   lost_mark_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      (p_pend && (hit != 4'h0) && !d_act) |=> (st.lost && !$changed(edge_source_flags_out)))
      else $error("second edge overwrote the record or was not marked lost");

   diag_incoming_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      (!d_act && diag_on && cause) |=>
      (diag_incoming_out && diag_active_out) ##1 !diag_incoming_out)
      else $error("diagnostic incoming not issued as one pulse");

   diag_going_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      (d_act && !cause) |=> (diag_going_out && !diag_active_out))
      else $error("diagnostic going not issued after cause cleared");

   diag_off_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      (!d_act && (diag_enable_in != eit_pkg::EIT_DIAG_ON)) |=> !diag_incoming_out)
      else $error("diagnostic interrupt raised while disabled");

   edge_discard_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      (d_act && !p_pend) |=> !proc_irq_out)
      else $error("edge stored during diagnostic window");

   telegram_kind_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      (!p_pend && (hit != 4'h0) && !d_act) |=> (proc_emergency_out == $past(canopen_mode_in)))
      else $error("telegram kind not latched with the record");

endmodule

/* File: rtl/eit_pkg.sv */
// Purpose: shared constants and types of the edge interrupt timestamp block
// Assumes: 40 MHz clock, four sense lines, record bytes read by subindex
// Notes: named figures of the block live here; the modules still write out widths and steps

package eit_pkg;

   // channels and parameter bytes
   localparam int EIT_CH = 4;
   localparam logic [7:0] EIT_DIAG_ON = 8'h40;
   localparam logic [7:0] EIT_DIAG_OFF = 8'h00;

   // timing
   localparam int EIT_CLK_NS = 25;
   localparam int EIT_US_NS = 1000;
   localparam int EIT_TICK_CYCLES = EIT_US_NS / EIT_CLK_NS;
   localparam int EIT_PRE_W = 6;
   localparam logic [EIT_PRE_W-1:0] EIT_PRE_LAST = EIT_PRE_W'(EIT_TICK_CYCLES - 1);
   localparam int EIT_TICK_W = 32;

   // process interrupt record subindices
   localparam logic [7:0] EIT_SX_FLAGS = 8'h02;
   localparam logic [7:0] EIT_SX_SNAP = 8'h03;
   localparam logic [7:0] EIT_SX_STAMP_HI = 8'h04;
   localparam logic [7:0] EIT_SX_STAMP_LO = 8'h05;

   // diagnostic byte field positions
   localparam int EIT_ERRD_OVF_BIT = 3;
   localparam int EIT_ERRD_LOST_BIT = 6;
   localparam int EIT_ERRA_CHAN_BIT = 3;

   // reset values
   localparam logic [7:0] EIT_BYTE_RST = 8'h00;
   localparam logic [15:0] EIT_STAMP_RST = 16'h0000;
   localparam logic [EIT_TICK_W-1:0] EIT_TICK_RST = 32'h0000_0000;

   // one-hot state codes
   typedef enum logic [1:0] {
      EIT_P_IDLE = 2'b01,
      EIT_P_PEND = 2'b10
   } eit_pstate_t;
   localparam int EIT_P_PEND_BIT = 1;

   typedef enum logic [1:0] {
      EIT_D_IDLE = 2'b01,
      EIT_D_ACT = 2'b10
   } eit_dstate_t;
   localparam int EIT_D_ACT_BIT = 1;

   typedef struct packed {
      logic armed;
      logic [EIT_CH-1:0] prev;
      eit_pstate_t pst;
      eit_dstate_t dst;
      logic [EIT_CH-1:0] flags;
      logic [EIT_CH-1:0] snap;
      logic [15:0] stamp;
      logic emcy;
      logic lost;
      logic [EIT_CH-1:0] chan_lost;
      logic diag_in;
      logic diag_go;
      logic [7:0] err_a;
      logic [7:0] err_d;
      logic [7:0] chan_err;
      logic [7:0] rd_byte;
   } eit_state_t;

   typedef struct packed {
      logic [EIT_PRE_W-1:0] pre;
      logic [EIT_TICK_W-1:0] count;
   } eit_tick_t;

endpackage

/* File: rtl/eit_us_ticker.sv */
// Purpose: free-running 32-bit microsecond ticker
// Assumes: clock period divides one microsecond exactly
// Notes: wraps to zero by plain overflow

`timescale 1ns/1ps

module eit_us_ticker (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // ticker value
   output logic [31:0] ticker_out
);

   eit_pkg::eit_tick_t st;
   eit_pkg::eit_tick_t next_st;

   always_comb begin
      next_st = st;
      if (st.pre == eit_pkg::EIT_PRE_LAST) begin
         next_st.pre = '0;
         next_st.count = st.count + 32'h0000_0001;
      end else begin
         next_st.pre = st.pre + 6'h01;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign ticker_out = st.count;

   tick_step_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (st.pre == eit_pkg::EIT_PRE_LAST) |=> (st.count == $past(st.count) + 32'h0000_0001))
      else $error("ticker did not step once per microsecond");

   tick_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (st.pre != eit_pkg::EIT_PRE_LAST) |=> $stable(st.count))
      else $error("ticker moved inside a microsecond");

endmodule

/* File: sim/eit_master_model.sv */
// Purpose: master side model that takes process records off the block
// Assumes: a record is taken by a one-cycle acknowledge
// Notes: the wait before acknowledging is set by the bench to model slow masters
`timescale 1ns/1ps
module eit_master_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // process interrupt handshake
   input wire logic proc_irq_in,
   input wire logic [7:0] ack_wait_in,
   output logic proc_ack_out
);
   logic [7:0] cnt;
   logic busy;
   // busy keeps a held-high request from being taken twice
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt <= 8'h00;
         busy <= 1'b0;
         proc_ack_out <= 1'b0;
      end else begin
         proc_ack_out <= 1'b0;
         if (!proc_irq_in) begin
            busy <= 1'b0;
            cnt <= 8'h00;
         end else if (!busy) begin
            if (cnt >= ack_wait_in) begin
               proc_ack_out <= 1'b1;
               busy <= 1'b1;
            end else begin
               cnt <= cnt + 8'h01;
            end
         end
      end
   end
endmodule

/* File: sim/edge_interrupt_timestamp_tb.sv */
// Purpose: self-checking bench of the edge interrupt block
// Assumes: 40 MHz clock, inputs driven 2 ns after the rising edge
// Notes: results are matched in order of appearance against a queue of notes
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
   $display("Error %0t: got %h want %h", $time, a, b); end end
module edge_interrupt_timestamp_tb;
   logic clk_in = 1'b0, nrst_in = 1'b0, canopen_mode_in = 1'b0, buffer_overflow_in = 1'b0;
   logic proc_ack_in;
   logic [3:0] sense_line_in = 4'h0;
   logic [7:0] rise_edge_irq_enable_in = 8'h00, fall_edge_irq_enable_in = 8'h00;
   logic [7:0] diag_enable_in = 8'h00, record_subindex_in = 8'h02, ack_wait = 8'h00;
   logic [7:0] record_byte_out, edge_source_flags_out, input_level_snapshot_out;
   logic [7:0] diag_err_a_out, diag_err_d_out, diag_chan_err_out;
   logic proc_irq_out, proc_emergency_out, diag_active_out, diag_incoming_out, diag_going_out;
   logic [15:0] timestamp_low_half_out;
   logic [31:0] ticker_out, t0, last_t;
   logic [39:0] exp_rec;
   logic [47:0] exp_q[$];
   int n_fail = 0, samples_checked = 0, i;
   logic [7:0] dv[3] = '{8'h00, 8'h41, 8'h40};

   initial begin
      forever #12.5 clk_in = ~clk_in;
   end

   eit_edge_irq dut_u (.clk_in, .nrst_in, .sense_line_in, .rise_edge_irq_enable_in,
      .fall_edge_irq_enable_in, .diag_enable_in, .canopen_mode_in, .buffer_overflow_in,
      .proc_ack_in, .record_subindex_in, .record_byte_out, .proc_irq_out, .proc_emergency_out,
      .edge_source_flags_out, .input_level_snapshot_out, .timestamp_low_half_out,
      .diag_active_out, .diag_incoming_out, .diag_going_out, .diag_err_a_out,
      .diag_err_d_out, .diag_chan_err_out, .ticker_out);
   eit_master_model master_u (.clk_in, .nrst_in, .proc_irq_in(proc_irq_out),
      .ack_wait_in(ack_wait), .proc_ack_out(proc_ack_in));

   task automatic results();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic bad(input string m);
      n_fail++;
      $display("Error %0t: %s", $time, m);
      results();
   endtask

   // a result with no note behind it is a spurious interrupt
   // the note is popped once into want, so a mismatch report cannot eat a second note
   task automatic take(input logic [47:0] got);
      logic [47:0] want;
      if (exp_q.size() == 0) begin
         n_fail++;
         $display("Error %0t: unexpected result %h", $time, got);
      end else begin
         want = exp_q.pop_front();
         `CHK(got, want)
      end
   endtask

   always @(posedge proc_irq_out) begin
      #1 take({8'h01, edge_source_flags_out, input_level_snapshot_out,
         timestamp_low_half_out, 7'h00, proc_emergency_out});
   end
   always @(posedge diag_incoming_out) begin
      #1 take({8'h02, diag_err_a_out, diag_err_d_out, diag_chan_err_out,
         15'h0000, diag_active_out});
   end
   always @(posedge diag_going_out) begin
      #1 take({8'h03, 39'h0, diag_active_out});
   end

   // returns just after the ticker moved, so it stays put for the next edges
   task automatic sync_tick(output logic [31:0] t);
      int k;
      t = ticker_out;
      for (k = 0; k < 60 && ticker_out === t; k++) begin
         @(posedge clk_in);
         #2;
      end
      if (k == 60) bad("ticker stuck");
      t = ticker_out;
   endtask

   task automatic hit(input int ch, input logic v, input logic want);
      sync_tick(last_t);
      sense_line_in[ch] = v;
      if (want) exp_q.push_back({8'h01, 4'h0, 4'h1 << ch, 4'h0, sense_line_in,
         last_t[15:0], 7'h00, canopen_mode_in});
      @(posedge clk_in);
      #2;
   endtask

   task automatic quiet();
      int k;
      for (k = 0; k < 400 && (proc_irq_out !== 1'b0 || diag_active_out !== 1'b0); k++) begin
         @(posedge clk_in);
         #2;
      end
      if (k == 400) bad("block never went quiet");
   endtask

   initial begin
      void'($urandom(21));
      repeat (8) @(posedge clk_in);
      #2 nrst_in = 1'b1;
      repeat (4) @(posedge clk_in);
      #2;
      `CHK({edge_source_flags_out, input_level_snapshot_out, ticker_out}, 48'h0)
      sync_tick(t0);
      repeat (39) @(posedge clk_in);
      #2 `CHK(ticker_out, t0)
      @(posedge clk_in);
      #2 `CHK(ticker_out, t0 + 32'h1)
      // reserved enable bits set high must change nothing
      rise_edge_irq_enable_in = 8'hf5;
      fall_edge_irq_enable_in = 8'hfa;
      for (i = 0; i < 4; i++) begin
         ack_wait = 8'($urandom_range(6, 0));
         canopen_mode_in = i[0];
         hit(i, 1'b1, rise_edge_irq_enable_in[i]);
         quiet();
         hit(i, 1'b0, fall_edge_irq_enable_in[i]);
         quiet();
      end
      exp_rec = {8'h08, 8'h00, last_t[15:8], last_t[7:0], 8'h00};
      for (i = 0; i < 5; i++) begin
         record_subindex_in = 8'h02 + 8'(i);
         @(posedge clk_in);
         #2 `CHK(record_byte_out, exp_rec[39-8*i -: 8])
      end
      // second edge while a record is held is lost and raises a diagnostic
      diag_enable_in = 8'h40;
      canopen_mode_in = 1'b0;
      rise_edge_irq_enable_in = 8'h07;
      ack_wait = 8'd200;
      hit(0, 1'b1, 1'b1);
      hit(1, 1'b1, 1'b0);
      exp_q.push_back({8'h02, 8'h08, 8'h40, 8'h02, 16'h0001});
      hit(2, 1'b1, 1'b0);
      exp_q.push_back({8'h03, 40'h0});
      quiet();
      // both directions off first, or dropping the lines would raise a fresh record
      rise_edge_irq_enable_in = 8'h00;
      fall_edge_irq_enable_in = 8'h00;
      sense_line_in = 4'h0;
      ack_wait = 8'h00;
      for (i = 0; i < 3; i++) begin
         diag_enable_in = dv[i];
         buffer_overflow_in = 1'b1;
         if (dv[i] == 8'h40) exp_q.push_back({8'h02, 8'h00, 8'h08, 8'h00, 16'h0001});
         repeat (5) @(posedge clk_in);
         #2 buffer_overflow_in = 1'b0;
         if (dv[i] == 8'h40) exp_q.push_back({8'h03, 40'h0});
         quiet();
         repeat (3) @(posedge clk_in);
         #2;
      end
      `CHK(exp_q.size(), 0)
      results();
   end
endmodule
